// file: timer_event_pkg.sv
package timer_event_pkg;

  // Special-register numbers of the three timer-event registers.
  localparam logic [9:0] SPR_STATUS  = 10'h3d8;
  localparam logic [9:0] SPR_CONTROL = 10'h3da;
  localparam logic [9:0] SPR_COUNTER = 10'h3db;

  // Fields are numbered from the most significant bit, so the ten control
  // bits sit at word bits 31:22 and the six status bits at 31:26.
  localparam int CTRL_LSB = 22;
  localparam int STAT_LSB = 26;

  // Time-base bit (counted from bit 0 of the low word) whose rise marks a
  // watchdog or fixed-interval event, indexed by the period code.
  localparam int WD_LSB [4] = '{16, 20, 24, 28};
  localparam int FX_LSB [4] = '{8, 12, 16, 20};

  // Reset codes shared by the reset-control and reset-cause fields.
  localparam logic [1:0] RST_NONE = 2'h0;

  // Reset values.
  localparam logic [31:0] CNT_RST = 32'h0;

  // Control word, most significant field first.
  typedef struct packed {
    logic [1:0] wdog_period;
    logic [1:0] wdog_reset_ctl;
    logic       wdog_irq_en;
    logic       interval_irq_en;
    logic [1:0] fixed_period_sel;
    logic       fixed_irq_en;
    logic       auto_reload_en;
  } ctrl_t;

  // Status word, most significant field first.
  typedef struct packed {
    logic       wdog_next_arm;
    logic       wdog_irq_flag;
    logic [1:0] wdog_reset_cause;
    logic       interval_irq_flag;
    logic       fixed_irq_flag;
  } stat_t;

  // One special-register move from the core.
  typedef struct packed {
    logic [9:0]  num;
    logic [31:0] wdata;
    logic        rd;
    logic        wr;
    logic        priv;
  } spr_req_t;

  // Whole state of the block.
  typedef struct packed {
    ctrl_t       ctrl;
    stat_t       stat;
    logic [31:0] cnt;
    logic [31:0] reload;
    logic        wd_prev;
    logic        fx_prev;
    logic [31:0] rdata;
    logic        rvalid;
    logic        priv_err;
    logic        wd_irq;
    logic        iv_irq;
    logic        fx_irq;
    logic        rst_pulse;
    logic [1:0]  rst_type;
  } state_t;

endpackage : timer_event_pkg

// file: processor_timer_event_regs.sv
`timescale 1ns/1ps

module processor_timer_event_regs
  import timer_event_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Special-register moves from the core.
  input  wire spr_req_t    spr_i,
  output logic [31:0]      spr_rdata_o,
  output logic             spr_rvalid_o,
  output logic             spr_priv_err_o,
  // Time base.
  input  wire logic        tb_tick_i,
  input  wire logic [31:0] timebase_low_i,
  // Interrupt requests.
  output logic             wdog_irq_o,
  output logic             interval_irq_o,
  output logic             fixed_irq_o,
  // Watchdog reset request.
  output logic             wdog_rst_o,
  output logic [1:0]       wdog_rst_type_o
);

  ////////////////////////////////////////////////////////////////////////////

  // Reset image of the state; auto-reload is off like every other bit.
  localparam state_t STATE_RST = '{
    ctrl:     ctrl_t'(10'h0),
    stat:     stat_t'(6'h0),
    cnt:      CNT_RST,
    reload:   CNT_RST,
    rdata:    32'h0,
    rst_type: RST_NONE,
    default:  1'b0
  };

  state_t s_q;
  state_t s_d;

  // Decoded access strobes.
  logic hit;
  logic rd_ok;
  logic wr_stat;
  logic wr_ctrl;
  logic wr_cnt;

  // Timer events.
  logic wd_bit;
  logic fx_bit;
  logic wd_edge;
  logic fx_edge;
  logic iv_event;

  ////////////////////////////////////////////////////////////////////////////

  // Address decode; unprivileged or unknown numbers touch nothing.
  // privileged decode only
  assign hit     = (spr_i.num == SPR_STATUS) || (spr_i.num == SPR_CONTROL)
                || (spr_i.num == SPR_COUNTER);
  assign rd_ok   = spr_i.rd && spr_i.priv && hit;
  assign wr_stat = spr_i.wr && spr_i.priv && (spr_i.num == SPR_STATUS);
  assign wr_ctrl = spr_i.wr && spr_i.priv && (spr_i.num == SPR_CONTROL);
  assign wr_cnt  = spr_i.wr && spr_i.priv && (spr_i.num == SPR_COUNTER);

  // Pick the time-base bits named by the period codes and find their rise.
  // A period change can show one early event; software sets periods first.
  // watchdog period select
  assign wd_bit  = timebase_low_i[WD_LSB[s_q.ctrl.wdog_period]];
  assign fx_bit  = timebase_low_i[FX_LSB[s_q.ctrl.fixed_period_sel]];
  assign wd_edge = wd_bit && !s_q.wd_prev;
  assign fx_edge = fx_bit && !s_q.fx_prev;

  // A software write beats a decrement in the same cycle.
  // interval event detect
  assign iv_event = tb_tick_i && (s_q.cnt == 32'h1) && !wr_cnt;

  ////////////////////////////////////////////////////////////////////////////

  // Next-state logic for the whole block.
  always_comb
  begin
    s_d           = s_q;
    s_d.rvalid    = 1'b0;
    s_d.rst_pulse = 1'b0;
    s_d.priv_err  = spr_i.rd || spr_i.wr ? hit && !spr_i.priv : 1'b0;
    s_d.wd_prev   = wd_bit;
    s_d.fx_prev   = fx_bit;

    // Register reads answer one cycle later.
    if (rd_ok)
    begin
      s_d.rvalid = 1'b1;
      if (spr_i.num == SPR_STATUS)
      begin
        s_d.rdata = {s_q.stat, 26'h0};
      end
      else if (spr_i.num == SPR_CONTROL)
      begin
        s_d.rdata = {s_q.ctrl, 22'h0};
      end
      else
      begin
        s_d.rdata = s_q.cnt;
      end
    end

    // Control write; the reset-control bits can only be added to.
    // reset control store
    if (wr_ctrl)
    begin
      s_d.ctrl = ctrl_t'(spr_i.wdata[31:CTRL_LSB]);
      s_d.ctrl.wdog_reset_ctl = s_d.ctrl.wdog_reset_ctl
                              | s_q.ctrl.wdog_reset_ctl;
    end

    // Interval counter: load, step down, reload or stop at zero.
    // counter step
    if (wr_cnt)
    begin
      s_d.cnt    = spr_i.wdata;
      s_d.reload = spr_i.wdata;
    end
    else if (tb_tick_i && (s_q.cnt != 32'h0))
    begin
      if (s_q.cnt == 32'h1)
      begin
        s_d.cnt = s_q.ctrl.auto_reload_en ? s_q.reload : 32'h0;
      end
      else
      begin
        s_d.cnt = s_q.cnt - 32'h1;
      end
    end

    // Clear mask first, so an event in the same cycle still sets its flag.
    // write one clears
    if (wr_stat)
    begin
      s_d.stat = s_q.stat & ~stat_t'(spr_i.wdata[31:STAT_LSB]);
    end

    if (iv_event)
    begin
      s_d.stat.interval_irq_flag = 1'b1;
    end
    if (fx_edge)
    begin
      s_d.stat.fixed_irq_flag = 1'b1;
    end

    // Watchdog sequence: arm, then flag, then reset if one is configured.
    // watchdog sequence
    if (wd_edge)
    begin
      if (!s_q.stat.wdog_next_arm)
      begin
        s_d.stat.wdog_next_arm = 1'b1;
      end
      else if (!s_q.stat.wdog_irq_flag)
      begin
        s_d.stat.wdog_irq_flag = 1'b1;
      end
      else if (s_q.ctrl.wdog_reset_ctl != RST_NONE)
      begin
        s_d.stat.wdog_reset_cause = s_q.ctrl.wdog_reset_ctl;
        s_d.rst_pulse             = 1'b1;
        s_d.rst_type              = s_q.ctrl.wdog_reset_ctl;
      end
    end

    // Requests follow the next flags so they line up with the status.
    // watchdog gate
    s_d.wd_irq = s_d.stat.wdog_irq_flag && s_d.ctrl.wdog_irq_en;
    s_d.iv_irq = s_d.stat.interval_irq_flag && s_d.ctrl.interval_irq_en;
    s_d.fx_irq = s_d.stat.fixed_irq_flag && s_d.ctrl.fixed_irq_en;
  end

  // State register.
  // reset clears mode
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s_q <= STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Outputs come straight from the state register.
  assign spr_rdata_o     = s_q.rdata;
  assign spr_rvalid_o    = s_q.rvalid;
  assign spr_priv_err_o  = s_q.priv_err;
  assign wdog_irq_o      = s_q.wd_irq;
  assign interval_irq_o  = s_q.iv_irq;
  assign fixed_irq_o     = s_q.fx_irq;
  assign wdog_rst_o      = s_q.rst_pulse;
  assign wdog_rst_type_o = s_q.rst_type;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // Steps of the watchdog sequence.
  sequence wd_armed_flagged;
    wd_edge && s_q.stat.wdog_next_arm && s_q.stat.wdog_irq_flag;
  endsequence

  sequence wd_fires;
    wd_armed_flagged ##0 (s_q.ctrl.wdog_reset_ctl != RST_NONE);
  endsequence

  sequence wd_first_out;
    wd_edge && !s_q.stat.wdog_next_arm;
  endsequence

  sequence wd_second_out;
    wd_edge && s_q.stat.wdog_next_arm && !s_q.stat.wdog_irq_flag;
  endsequence

  a_iv_event_flag: assert property (
    iv_event |=> s_q.stat.interval_irq_flag)
    else $error("interval event did not set its flag");

  a_iv_reload_value: assert property (
    iv_event && s_q.ctrl.auto_reload_en |=> s_q.cnt == $past(s_q.reload))
    else $error("auto reload did not restore the counter");

  a_iv_oneshot_zero: assert property (
    iv_event && !s_q.ctrl.auto_reload_en |=> (s_q.cnt == 32'h0) [*2]
      or (s_q.cnt == 32'h0) ##1 $past(wr_cnt))
    else $error("one-shot counter left zero on its own");

  a_iv_step_down: assert property (
    tb_tick_i && !wr_cnt && (s_q.cnt > 32'h1)
      |=> s_q.cnt == $past(s_q.cnt) - 32'h1)
    else $error("counter did not step down by one");

  a_wrc_sticky: assert property (
    ($past(s_q.ctrl.wdog_reset_ctl) & ~s_q.ctrl.wdog_reset_ctl) == 2'h0)
    else $error("reset control bit was cleared");

  a_wdog_reset_req: assert property (
    wd_fires |=> wdog_rst_o
      && wdog_rst_type_o == $past(s_q.ctrl.wdog_reset_ctl)
      && s_q.stat.wdog_reset_cause == wdog_rst_type_o ##1 !wdog_rst_o)
    else $error("watchdog reset not requested with the right type");

  a_wdog_no_early: assert property (
    wdog_rst_o |-> $past(wd_edge && s_q.stat.wdog_irq_flag))
    else $error("watchdog reset without a flagged time-out");

  a_status_clear: assert property (
    wr_stat && spr_i.wdata[STAT_LSB + 1] && !iv_event
      |=> !s_q.stat.interval_irq_flag)
    else $error("status write did not clear the flag");

  a_irq_gate: assert property (
    ##1 interval_irq_o == (s_q.stat.interval_irq_flag
      && s_q.ctrl.interval_irq_en)
      && fixed_irq_o == (s_q.stat.fixed_irq_flag && s_q.ctrl.fixed_irq_en))
    else $error("interrupt output disagrees with flag and enable");

  a_priv_guard: assert property (
    spr_i.wr && !spr_i.priv && !wd_edge && !fx_edge && !iv_event
      |=> $stable(s_q.ctrl) && $stable(s_q.stat)
      && spr_priv_err_o == $past(hit))
    else $error("unprivileged write changed a register");

  // Watchdog steps, event flags, mode after reset and read answers.
  a_wdog_arm_step: assert property (
    wd_first_out |=> s_q.stat.wdog_next_arm)
    else $error("first watchdog time-out did not arm");

  a_wdog_flag_step: assert property (
    wd_second_out |=> s_q.stat.wdog_irq_flag && !wdog_rst_o)
    else $error("second watchdog time-out did not set its flag");

  a_fixed_event_flag: assert property (
    fx_edge |=> s_q.stat.fixed_irq_flag)
    else $error("fixed-interval event did not set its flag");

  a_wdog_irq_gate: assert property (
    wdog_irq_o == (s_q.stat.wdog_irq_flag && s_q.ctrl.wdog_irq_en))
    else $error("watchdog interrupt disagrees with flag and enable");

  a_reload_off_reset: assert property (
    $past(rst_i) |-> !s_q.ctrl.auto_reload_en)
    else $error("auto-reload was on after reset");

  a_counter_hold_zero: assert property (
    s_q.cnt == 32'h0 && !wr_cnt |=> s_q.cnt == 32'h0)
    else $error("empty counter moved without a write");

  a_read_answer: assert property (
    rd_ok |=> spr_rvalid_o)
    else $error("privileged read got no answer");

  a_read_quiet: assert property (
    !rd_ok |=> !spr_rvalid_o)
    else $error("read answer without an accepted read");

  a_status_read: assert property (
    rd_ok && spr_i.num == SPR_STATUS
      |=> spr_rdata_o == {$past(s_q.stat), 26'h0})
    else $error("status read returned the wrong word");

endmodule : processor_timer_event_regs

// file: processor_timer_event_regs_test.sv
`timescale 1ns/1ps

module processor_timer_event_regs_test
  import timer_event_pkg::*;
;

  // Stimulus and observed outputs.
  logic        clock_i;
  logic        rst_i;
  spr_req_t    spr;
  logic        tick;
  logic [31:0] timebase_low;
  logic [31:0] rdata;
  logic        rvalid;
  logic        priv_err;
  logic        wd_irq;
  logic        iv_irq;
  logic        fx_irq;
  logic        wd_rst;
  logic [1:0]  wd_type;
  int          mismatches;
  int          checked;
  int          rst_seen;

  processor_timer_event_regs DUT (
    .clock_i        (clock_i),
    .rst_i          (rst_i),
    .spr_i          (spr),
    .spr_rdata_o    (rdata),
    .spr_rvalid_o   (rvalid),
    .spr_priv_err_o (priv_err),
    .tb_tick_i      (tick),
    .timebase_low_i (timebase_low),
    .wdog_irq_o     (wd_irq),
    .interval_irq_o (iv_irq),
    .fixed_irq_o    (fx_irq),
    .wdog_rst_o     (wd_rst),
    .wdog_rst_type_o(wd_type)
  );

  // Half period of 20 ns gives 25 MHz.
  always #20 clock_i = ~clock_i;

  // The reset pulse lasts one cycle, so it is counted rather than polled.
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rst_seen <= 0;
    end
    else if (wd_rst === 1'b1)
    begin
      rst_seen <= rst_seen + 1;
    end
  end

  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [9:0] num, input logic [31:0] d,
                           input logic priv = 1'b1);
    @(posedge clock_i);
    spr <= '{num: num, wdata: d, rd: 1'b0, wr: 1'b1, priv: priv};
    @(posedge clock_i);
    spr.wr <= 1'b0;
  endtask : reg_write

  // Waits a bounded number of cycles for the read answer.
  task automatic reg_read(input logic [9:0] num, input logic [31:0] exp);
    int n;
    @(posedge clock_i);
    spr <= '{num: num, wdata: 32'h0, rd: 1'b1, wr: 1'b0, priv: 1'b1};
    @(posedge clock_i);
    spr.rd <= 1'b0;
    #1;
    n = 0;
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n == 4)
    begin
      mismatches++;
      report_and_stop();
    end
    check("read latency", 32'h0, n);
    check($sformatf("register %h", num), exp, rdata);
  endtask : reg_read

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clock_i);
      tick <= 1'b1;
      @(posedge clock_i);
      tick <= 1'b0;
    end
  endtask : ticks

  // One rising edge of a single time-base bit.
  task automatic rise(input int b);
    @(posedge clock_i);
    timebase_low <= 32'h1 << b;
    @(posedge clock_i);
    timebase_low <= 32'h0;
  endtask : rise

  ////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    spr = '0;
    tick = 1'b0;
    timebase_low = 32'h0;
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    reg_read(SPR_CONTROL, 32'h0);
    reg_read(SPR_STATUS, 32'h0);
    reg_read(SPR_COUNTER, 32'h0);
    reg_write(SPR_CONTROL, 32'hffc0_0000);
    reg_read(SPR_CONTROL, 32'hffc0_0000);
    reg_write(SPR_CONTROL, 32'h0);
    reg_read(SPR_CONTROL, 32'h3000_0000);
    reg_write(SPR_COUNTER, 32'h5, 1'b0);
    #1 check("priv err", 32'h1, {31'h0, priv_err});
    reg_read(SPR_COUNTER, 32'h0);
    // One-shot countdown with the interval interrupt enabled.
    reg_write(SPR_CONTROL, 32'h0400_0000);
    reg_write(SPR_COUNTER, 32'h2);
    ticks(1);
    reg_read(SPR_COUNTER, 32'h1);
    ticks(2);
    reg_read(SPR_COUNTER, 32'h0);
    reg_read(SPR_STATUS, 32'h0800_0000);
    check("interval irq", 32'h1, {31'h0, iv_irq});
    reg_write(SPR_STATUS, 32'h0800_0000);
    reg_read(SPR_STATUS, 32'h0);
    check("interval irq", 32'h0, {31'h0, iv_irq});
    // Auto-reload with the interrupt masked: flag set, no request.
    reg_write(SPR_CONTROL, 32'h0040_0000);
    reg_write(SPR_COUNTER, 32'h3);
    ticks(3);
    reg_read(SPR_COUNTER, 32'h3);
    reg_read(SPR_STATUS, 32'h0800_0000);
    check("interval irq", 32'h0, {31'h0, iv_irq});
    reg_write(SPR_STATUS, 32'hffff_ffff);
    // Every fixed period code; watchdog parked on its slowest bit.
    for (int c = 0; c < 4; c++)
    begin
      reg_write(SPR_CONTROL, {2'h3, 4'h0, c[1:0], 1'h1, 23'h0});
      rise(8 + 4 * c);
      reg_read(SPR_STATUS, 32'h0400_0000);
      check("fixed irq", 32'h1, {31'h0, fx_irq});
      reg_write(SPR_STATUS, 32'hffff_ffff);
    end
    // Every watchdog period code; reset control is stuck at system.
    for (int c = 0; c < 4; c++)
    begin
      reg_write(SPR_CONTROL, {c[1:0], 3'h1, 27'h0});
      rise(16 + 4 * c);
      reg_read(SPR_STATUS, 32'h8000_0000);
      rise(16 + 4 * c);
      reg_read(SPR_STATUS, 32'hc000_0000);
      check("wdog irq", 32'h1, {31'h0, wd_irq});
      rise(16 + 4 * c);
      reg_read(SPR_STATUS, 32'hf000_0000);
      check("wdog resets", c + 1, rst_seen);
      check("wdog type", 32'h3, {30'h0, wd_type});
      reg_write(SPR_STATUS, 32'hffff_ffff);
    end
    // Mid-run reset must clear the sticky reset-control bits and the counter.
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    reg_read(SPR_CONTROL, 32'h0);
    reg_read(SPR_COUNTER, 32'h0);
    report_and_stop();
  end

endmodule : processor_timer_event_regs_test
